// ### src/ppl_peak_power_limit_control.sv
// Purpose: control logic of a buck-boost charge controller
// Assumes: analog quantities arrive as codes on clk_sys; comparator pins async
// Notes: voltages mV, currents mA, sense voltages uV
//
// Summary of operation
// - high side until ramp crosses, then low
// - dead interval between switch transitions always
// - pulse skipping at light load, 25 kHz floor
// - fixed frequency from frequency select bit
// - spread select off, or 2/4/6 percent
// - input monitor gain 20/40, reversed in reverse
// - battery monitor gain 8/16, polarity by mode
// - input monitor valid once any UVLO cleared
// - power monitor gain field, 1 uA/W default
// - power config selects bus plus battery, bus or none
// - power config resets to disabled
// - input limit breach cuts charge current
// - battery supplements when charge command is zero and system below battery
// - base is limit, overload is percentage
// - trigger applies overload then base limit
// - still loaded at period end restarts cycle
// - charging suspended after overload, until period end
// - input voltage limit starts at no-load minus 1.28 V
`timescale 1ns/100ps
`default_nettype none
module ppl_peak_power_limit_control
    import ppl_pkg::*;
#(
    parameter logic [15:0] CHG_STEP_MA = 16'h0040
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic converterEnable,
    input wire logic rampAboveErr,
    input wire logic lightLoad,
    input wire logic vinUvloOk,
    input wire logic vbatUvloOk,
    input wire logic switchingFrequencySelect,
    input wire logic [1:0] spreadSelect,
    input wire logic audibleNoiseAvoidEnable,
    input wire logic signed [15:0] inputSense,
    input wire logic signed [15:0] batSense,
    input wire logic [15:0] inputVolt,
    input wire logic [15:0] sysVolt,
    input wire logic [15:0] batVolt,
    input wire logic [15:0] busNoLoad,
    input wire logic [15:0] minimumSystemVoltage,
    input wire logic reverseMode,
    input wire logic batteryOnly,
    input wire logic imonGainHigh,
    input wire logic bmonGainHigh,
    input wire logic [3:0] powerMonitorGain,
    input wire logic powerMonitorGainWrite,
    input wire logic [1:0] powerMonitorConfig,
    input wire logic powerMonitorConfigWrite,
    input wire logic reverseBatteryOnly,
    input wire logic inputSenseResSelect,
    input wire logic chargeSenseResSelect,
    input wire logic [15:0] inputCurrentLimit,
    input wire logic [7:0] overloadPercentage,
    input wire logic [15:0] overloadDuration,
    input wire logic [15:0] peakCyclePeriod,
    input wire logic inputLimitEnable,
    input wire logic externalLimitEnable,
    input wire logic systemUndershootPeakEnable,
    input wire logic inputOvershootPeakEnable,
    input wire logic [15:0] hostVinLimit,
    input wire logic hostVinLimitWrite,
    input wire logic [15:0] chargeCurrentRequest,
    output logic highSideSwitchOn,
    output logic lowSideSwitchOn,
    output logic signed [15:0] inputCurrentMonitorOut,
    output logic inputMonitorValid,
    output logic signed [15:0] batteryCurrentMonitorOut,
    output logic [15:0] systemPowerMonitorOut,
    output logic [15:0] inputVoltageLimit,
    output logic [15:0] activeInputLimit,
    output logic overloadActive,
    output logic chargeSuspended,
    output logic [15:0] chargeCurrentCmd,
    output logic supplementEnable
);
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PK_IDLE = 3'b001,
        PK_OVER = 3'b010,
        PK_BASE = 3'b100
    } ppl_pk_type;

    typedef struct packed {
        logic [2:0] syncA;
        logic [2:0] syncB;
        logic imonValid;
        logic signed [15:0] imon;
        logic signed [15:0] bmon;
        logic [15:0] pmon;
        logic [3:0] pmGain;
        logic [1:0] pmCfg;
        logic [15:0] vinLim;
        logic vinLimInit;
        logic [6:0] tickCnt;
        logic tick;
        ppl_pk_type pk;
        logic overload;
        logic [15:0] ovCnt;
        logic [15:0] cyCnt;
        logic [15:0] limit;
        logic suspend;
        logic [15:0] chg;
        logic supp;
    } ppl_st_type;

    ppl_st_type st_r, st_nxt;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // gain times sense in uV, reported in mV, saturated to 16 bits
    function automatic logic signed [15:0] scaleSat(input logic signed [15:0] v,
                                                    input int gain,
                                                    input logic neg);
        logic signed [31:0] p;
        p = 32'(v) * 32'(gain);
        if (neg)
            p = -p;
        p = p / 32'sd1000;
        if (p > 32'sd32767)
            scaleSat = 16'sh7fff;
        else if (p < -32'sd32768)
            scaleSat = -16'sh8000;
        else
            scaleSat = 16'(p);
    endfunction

    // sense uV to mA; select set means the 5 mOhm resistor
    function automatic logic signed [31:0] senseToMa(input logic signed [15:0] v,
                                                     input logic sel5);
        senseToMa = sel5 ? 32'(v) / 32'sd5 : 32'(v) / 32'sd10;
    endfunction

    // clamp and quantise an input voltage limit to its legal grid
    function automatic logic [15:0] clampVin(input logic signed [16:0] v);
        logic [15:0] q;
        q = VIN_LIM_MIN_MV;
        if (v > $signed({1'b0, VIN_LIM_MAX_MV}))
            q = VIN_LIM_MAX_MV;
        else if (v > $signed({1'b0, VIN_LIM_MIN_MV}))
            q = v[15:0] & VIN_LIM_STEP_MASK;
        clampVin = q;
    endfunction

    // either supply above lockout validates the input monitor
    function automatic logic uvloSrc(input logic a, input logic b);
        uvloSrc = a | b;
    endfunction

    // ----------------------------------------------------------------
    // synchronised pins
    // ----------------------------------------------------------------
    // syncA: stage one, read only by syncB
    logic rampS;
    logic lightS;
    logic uvloS;
    assign rampS = st_r.syncB[0];
    assign lightS = st_r.syncB[1];
    assign uvloS = st_r.syncB[2];

    // ----------------------------------------------------------------
    // switching cycle
    // ----------------------------------------------------------------
    logic cycleStart;

    ppl_freq_gen ppl_freq_gen_inst
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .freqSelHigh(switchingFrequencySelect),
        .spreadSelect(spreadSelect),
        .lightLoad(lightS),
        .noiseAvoidEn(audibleNoiseAvoidEnable),
        .cycleStart(cycleStart)
    );

    ppl_switch_seq ppl_switch_seq_inst
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .enable(converterEnable),
        .cycleStart(cycleStart),
        .rampAboveErr(rampS),
        .lightLoad(lightS),
        .highSideOn(highSideSwitchOn),
        .lowSideOn(lowSideSwitchOn)
    );

    // ----------------------------------------------------------------
    // combinational terms
    // ----------------------------------------------------------------
    logic signed [31:0] iinMa;
    logic signed [31:0] ibatMa;
    logic signed [31:0] pBus;
    logic signed [31:0] pBat;
    logic signed [31:0] pSel;
    logic signed [31:0] pOut;
    logic [15:0] baseLim;
    logic [15:0] overLim;
    logic [31:0] overProd;
    logic trigger;
    logic peakAllowed;
    logic limiting;
    logic [15:0] chgTarget;
    logic bmonRev;

    assign iinMa = senseToMa(inputSense, inputSenseResSelect);
    assign ibatMa = senseToMa(batSense, chargeSenseResSelect);
    assign pBus = ($signed({16'h0000, inputVolt}) * iinMa) / 32'sd1000;
    assign pBat = ($signed({16'h0000, sysVolt}) * ibatMa) / 32'sd1000;

    // reported power follows the config field and the direction
    always_comb
    begin
        pSel = 32'sd0;
        case (st_r.pmCfg)
            PMON_BOTH:
                pSel = (reverseMode && reverseBatteryOnly) ? pBat : pBus + pBat;
            PMON_BUS:
                pSel = reverseMode ? 32'sd0 : pBus;
            default:
                pSel = 32'sd0;
        endcase
    end

    // power in mW times gain in uA/W gives nA; reported in uA
    assign pOut = (pSel * $signed({28'h0000000, st_r.pmGain})) / 32'sd1000;

    // the overload limit is a percentage of the base limit
    assign baseLim = inputCurrentLimit;
    assign overProd = (32'(inputCurrentLimit) * 32'(overloadPercentage)) / 32'(PCT_DIV);
    assign overLim = (overProd > 32'h0000ffff) ? 16'hffff : overProd[15:0];

    // peak operation relies on the host having set the limit path up
    assign peakAllowed = inputLimitEnable && !externalLimitEnable;
    assign trigger = peakAllowed &&
                     ((inputOvershootPeakEnable && (iinMa > $signed({16'h0000, baseLim})) && (batSense < 0)) ||
                      (systemUndershootPeakEnable && (sysVolt < minimumSystemVoltage)));

    // charge is cut when either input limit is breached
    assign limiting = (inputLimitEnable && (iinMa > $signed({16'h0000, st_r.limit}))) ||
                      (inputVolt < st_r.vinLim);
    assign chgTarget = st_r.suspend ? 16'h0000 : chargeCurrentRequest;
    assign bmonRev = reverseMode || batteryOnly || st_r.supp;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.syncA = {uvloSrc(vinUvloOk, vbatUvloOk), lightLoad, rampAboveErr};
        st_nxt.syncB = st_r.syncA;

        // time base, one pulse per tick period
        st_nxt.tick = 1'b0;
        st_nxt.tickCnt = st_r.tickCnt + 7'h01;
        if (st_r.tickCnt >= TICK_CYC - 7'h01)
        begin
            st_nxt.tickCnt = 7'h00;
            st_nxt.tick = 1'b1;
        end

        // monitors
        st_nxt.imonValid = uvloS;
        st_nxt.imon = uvloS ? scaleSat(inputSense, imonGainHigh ? IMON_GAIN_HI : IMON_GAIN_LO,
                                       reverseMode) : 16'sh0000;
        st_nxt.bmon = scaleSat(batSense, bmonGainHigh ? BMON_GAIN_HI : BMON_GAIN_LO, bmonRev);
        if (powerMonitorGainWrite)
            st_nxt.pmGain = powerMonitorGain;
        if (powerMonitorConfigWrite)
            st_nxt.pmCfg = powerMonitorConfig;
        // the monitor cannot source negative current; clamp at zero
        if (pOut < 32'sd0)
            st_nxt.pmon = 16'h0000;
        else if (pOut > 32'sd65535)
            st_nxt.pmon = 16'hffff;
        else
            st_nxt.pmon = pOut[15:0];

        // input voltage limit: measured once before the converter runs
        if (hostVinLimitWrite)
        begin
            st_nxt.vinLim = clampVin($signed({1'b0, hostVinLimit}));
            st_nxt.vinLimInit = 1'b0;
        end
        else if (st_r.vinLimInit && converterEnable)
        begin
            st_nxt.vinLim = clampVin($signed({1'b0, busNoLoad}) - $signed({1'b0, VIN_LIM_OFFSET_MV}));
            st_nxt.vinLimInit = 1'b0;
        end

        // peak power cycle; counters run on the tick
        if (st_r.tick)
        begin
            st_nxt.ovCnt = (st_r.ovCnt == 16'hffff) ? st_r.ovCnt : st_r.ovCnt + 16'h0001;
            st_nxt.cyCnt = (st_r.cyCnt == 16'hffff) ? st_r.cyCnt : st_r.cyCnt + 16'h0001;
        end
        case (st_r.pk)
            PK_IDLE:
                if (trigger)
                begin
                    st_nxt.pk = PK_OVER;
                    st_nxt.ovCnt = 16'h0000;
                    st_nxt.cyCnt = 16'h0000;
                end
            PK_OVER:
                if (st_r.ovCnt >= overloadDuration)
                    st_nxt.pk = PK_BASE;
            PK_BASE:
                if (st_r.cyCnt >= peakCyclePeriod)
                begin
                    if (trigger)
                    begin
                        st_nxt.pk = PK_OVER;
                        st_nxt.ovCnt = 16'h0000;
                        st_nxt.cyCnt = 16'h0000;
                    end
                    else
                        st_nxt.pk = PK_IDLE;
                end
            default:
                st_nxt.pk = PK_IDLE;
        endcase
        if (!peakAllowed)
            st_nxt.pk = PK_IDLE;
        st_nxt.limit = (st_nxt.pk == PK_OVER) ? overLim : baseLim;
        st_nxt.overload = (st_nxt.pk == PK_OVER);
        st_nxt.suspend = (st_nxt.pk == PK_BASE);

        // charge current: step down while limiting, toward target otherwise
        if (st_r.tick)
        begin
            if (limiting || (st_r.chg > chgTarget))
                st_nxt.chg = (st_r.chg > CHG_STEP_MA) ? st_r.chg - CHG_STEP_MA : 16'h0000;
            else if (st_r.chg < chgTarget)
                st_nxt.chg = (chgTarget - st_r.chg > CHG_STEP_MA) ? st_r.chg + CHG_STEP_MA : chgTarget;
        end
        // zero in the same cycle the suspend flag rises, not one later
        if (st_nxt.suspend)
            st_nxt.chg = 16'h0000;
        st_nxt.supp = (st_r.chg == 16'h0000) && (sysVolt < batVolt);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= '0;
            st_r.pmGain <= PMON_GAIN_RST;
            st_r.pmCfg <= PMON_CFG_RST;
            st_r.vinLim <= VIN_LIM_MIN_MV;
            st_r.vinLimInit <= 1'b1;
            st_r.pk <= PK_IDLE;
        end
        else
            st_r <= st_nxt;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign inputCurrentMonitorOut = st_r.imon;
    assign inputMonitorValid = st_r.imonValid;
    assign batteryCurrentMonitorOut = st_r.bmon;
    assign systemPowerMonitorOut = st_r.pmon;
    assign inputVoltageLimit = st_r.vinLim;
    assign activeInputLimit = st_r.limit;
    assign overloadActive = st_r.overload;
    assign chargeSuspended = st_r.suspend;
    assign chargeCurrentCmd = st_r.chg;
    assign supplementEnable = st_r.supp;
endmodule // ppl_peak_power_limit_control
`default_nettype wire

// ### include/ppl_pkg.sv
// Purpose: shared constants for the peak power limit control block
// Assumes: 100 MHz system clock; voltages in mV, currents in mA, sense in uV
// Notes: timing counts are derived from the clock rate
package ppl_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int FSW_LO_HZ = 400_000;
    localparam int FSW_HI_HZ = 800_000;
    localparam logic [9:0] PERIOD_LO = 10'(CLK_HZ / FSW_LO_HZ);
    localparam logic [9:0] PERIOD_HI = 10'(CLK_HZ / FSW_HI_HZ);
    localparam int SKIP_MIN_HZ = 25_000;
    localparam logic [11:0] SKIP_MAX_CYC = 12'(CLK_HZ / SKIP_MIN_HZ);
    localparam int DEAD_NS = 20;
    localparam logic [3:0] DEAD_CYC = 4'((DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
    localparam int TICK_NS = 1000;
    localparam logic [6:0] TICK_CYC = 7'(TICK_NS / (1_000_000_000 / CLK_HZ));
    // ----------------------------------------------------------------
    // field encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] SPREAD_OFF = 2'h0;
    localparam logic [1:0] PMON_BOTH = 2'h0;
    localparam logic [1:0] PMON_BUS = 2'h1;
    localparam logic [1:0] PMON_CFG_RST = 2'h3;
    localparam logic [3:0] PMON_GAIN_RST = 4'h1;
    localparam int IMON_GAIN_LO = 20;
    localparam int IMON_GAIN_HI = 40;
    localparam int BMON_GAIN_LO = 8;
    localparam int BMON_GAIN_HI = 16;
    localparam logic [15:0] VIN_LIM_OFFSET_MV = 16'h0500;
    localparam logic [15:0] VIN_LIM_MIN_MV = 16'h0c80;
    localparam logic [15:0] VIN_LIM_MAX_MV = 16'h4c40;
    localparam logic [15:0] VIN_LIM_STEP_MASK = 16'hffc0;
    localparam int PCT_DIV = 100;
endpackage

// ### src/ppl_freq_gen.sv
// Purpose: switching cycle timer with spread and pulse skipping
// Assumes: all inputs are on clk_sys
// Notes: spread is a triangle offset on the period
`timescale 1ns/100ps
`default_nettype none
module ppl_freq_gen
    import ppl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic freqSelHigh,
    input wire logic [1:0] spreadSelect,
    input wire logic lightLoad,
    input wire logic noiseAvoidEn,
    output logic cycleStart
);
    typedef struct packed {
        logic [9:0] cnt;
        logic signed [5:0] dither;
        logic triUp;
        logic [11:0] since;
        logic pulse;
    } ppl_fg_type;
    ppl_fg_type st_r, st_nxt;

    // spread span in cycles: period times 2, 4 or 6 percent
    function automatic logic [5:0] spanOf(input logic [9:0] base, input logic [1:0] sel);
        spanOf = 6'((int'(base) * 2 * int'(sel)) / PCT_DIV);
    endfunction

    logic [9:0] base;
    logic [5:0] span;
    logic [9:0] period;
    assign base = freqSelHigh ? PERIOD_HI : PERIOD_LO;
    assign span = spanOf(base, spreadSelect);
    assign period = 10'($signed({1'b0, base}) + st_r.dither);

    // end of a cycle either fires a pulse or is skipped at light load
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pulse = 1'b0;
        st_nxt.since = (st_r.since == 12'hfff) ? st_r.since : st_r.since + 12'h001;
        st_nxt.cnt = st_r.cnt + 10'h001;
        if (st_r.cnt >= period - 10'h001)
        begin
            st_nxt.cnt = 10'h000;
            // keep the skipped gap under the audible floor when asked
            // compare against the floor minus one period so the sum cannot wrap
            if (!lightLoad || (noiseAvoidEn && (st_r.since >= SKIP_MAX_CYC - 12'(period))))
            begin
                st_nxt.pulse = 1'b1;
                st_nxt.since = 12'h000;
            end
            // triangle walk, held at zero when spread is off
            if (spreadSelect == SPREAD_OFF)
                st_nxt.dither = 6'sd0;
            else if (st_r.triUp && (st_r.dither >= $signed(span)))
                st_nxt.triUp = 1'b0;
            else if (!st_r.triUp && (st_r.dither <= -$signed(span)))
                st_nxt.triUp = 1'b1;
            else
                st_nxt.dither = st_r.triUp ? st_r.dither + 6'sd1 : st_r.dither - 6'sd1;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            st_r <= '{cnt: 10'h000, dither: 6'sd0, triUp: 1'b1, since: 12'h000, pulse: 1'b0};
        else
            st_r <= st_nxt;
    end

    assign cycleStart = st_r.pulse;
endmodule // ppl_freq_gen
`default_nettype wire

// ### src/ppl_switch_seq.sv
// Purpose: high and low side switch sequencing with dead time
// Assumes: rampAboveErr is already synchronised
// Notes: a switch is only turned on from a dead interval
`timescale 1ns/100ps
`default_nettype none
module ppl_switch_seq
    import ppl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic cycleStart,
    input wire logic rampAboveErr,
    input wire logic lightLoad,
    output logic highSideOn,
    output logic lowSideOn
);
    typedef enum logic [4:0] {
        SW_OFF = 5'b00001,
        SW_DEAD_H = 5'b00010,
        SW_HIGH = 5'b00100,
        SW_DEAD_L = 5'b01000,
        SW_LOW = 5'b10000
    } ppl_sw_type;
    typedef struct packed {
        ppl_sw_type sw;
        logic [3:0] dead;
        logic hs;
        logic ls;
    } ppl_seq_type;
    ppl_seq_type st_r, st_nxt;

    // phase machine; outputs are decoded from the next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.dead = (st_r.dead == 4'h0) ? 4'h0 : st_r.dead - 4'h1;
        case (st_r.sw)
            SW_OFF:
                if (cycleStart)
                begin
                    st_nxt.sw = SW_DEAD_H;
                    st_nxt.dead = DEAD_CYC;
                end
            SW_DEAD_H:
                if (st_r.dead <= 4'h1)
                    st_nxt.sw = SW_HIGH;
            SW_HIGH:
                if (rampAboveErr)
                begin
                    st_nxt.sw = SW_DEAD_L;
                    st_nxt.dead = DEAD_CYC;
                end
            SW_DEAD_L:
                if (st_r.dead <= 4'h1)
                    st_nxt.sw = SW_LOW;
            SW_LOW:
                if (cycleStart)
                begin
                    st_nxt.sw = SW_DEAD_H;
                    st_nxt.dead = DEAD_CYC;
                end
                else if (lightLoad)
                    st_nxt.sw = SW_OFF;
            default:
                st_nxt.sw = SW_OFF;
        endcase
        if (!enable)
            st_nxt.sw = SW_OFF;
        st_nxt.hs = (st_nxt.sw == SW_HIGH);
        st_nxt.ls = (st_nxt.sw == SW_LOW);
    end

    // state register
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            st_r <= '{sw: SW_OFF, dead: 4'h0, hs: 1'b0, ls: 1'b0};
        else
            st_r <= st_nxt;
    end

    assign highSideOn = st_r.hs;
    assign lowSideOn = st_r.ls;
endmodule // ppl_switch_seq
`default_nettype wire

// ### dv/ppl_chk.sv
// Purpose: port checks
// Assumes: one clock
// Notes: bound below
`timescale 1ns/100ps
`default_nettype none
module ppl_chk
    import ppl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic highSideSwitchOn,
    input wire logic lowSideSwitchOn,
    input wire logic [15:0] inputVoltageLimit,
    input wire logic [15:0] activeInputLimit,
    input wire logic [15:0] inputCurrentLimit,
    input wire logic overloadActive,
    input wire logic chargeSuspended,
    input wire logic [15:0] chargeCurrentCmd,
    input wire logic supplementEnable
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // phases, limits and charge gating
    a_no_overlap: assert property (!(highSideSwitchOn && lowSideSwitchOn)) else $error("overlap");
    a_dead_high: assert property ($fell(highSideSwitchOn) |-> !lowSideSwitchOn[*2]) else $error("dead");
    a_dead_low: assert property ($fell(lowSideSwitchOn) |-> !highSideSwitchOn[*2]) else $error("dead");
    a_base_limit: assert property ($past(reset_n) && !overloadActive && $stable(inputCurrentLimit)
        |-> activeInputLimit == inputCurrentLimit) else $error("base");
    a_suspend_zero: assert property (chargeSuspended |-> chargeCurrentCmd == 16'h0) else $error("cmd");
    a_phase_split: assert property (!(overloadActive && chargeSuspended)) else $error("phase");
    a_supply_cause: assert property ($rose(supplementEnable) |-> $past(chargeCurrentCmd) == 16'h0) else $error("sup");
    a_vin_range: assert property (inputVoltageLimit >= VIN_LIM_MIN_MV && inputVoltageLimit <= VIN_LIM_MAX_MV
        && inputVoltageLimit[5:0] == 6'h0) else $error("vin");
    c_over: cover property ($rose(overloadActive));
    c_susp: cover property ($rose(chargeSuspended));
    c_low: cover property ($rose(lowSideSwitchOn));
endmodule // ppl_chk
bind ppl_peak_power_limit_control ppl_chk ppl_chk_inst (.*);
`default_nettype wire

// ### dv/ppl_stage_model.sv
// Purpose: stage model closing the ramp loop
// Assumes: ramp restarts while the low side conducts
// Notes: slow delays the trip like heavy load
`timescale 1ns/100ps
`default_nettype none
module ppl_stage_model
(
    input wire logic clk_sys,
    input wire logic highSideSwitchOn,
    input wire logic lowSideSwitchOn,
    input wire logic slow,
    output logic rampAboveErr
);
    logic [7:0] ramp_r = 8'h0;
    // ramp climbs only on the high side; saturate so a long phase cannot wrap
    always_ff @(posedge clk_sys)
    begin
        ramp_r <= lowSideSwitchOn ? 8'h0 : ramp_r + {7'h0, highSideSwitchOn && !(&ramp_r)};
    end
    assign rampAboveErr = ramp_r >= (slow ? 8'h50 : 8'h10);
endmodule // ppl_stage_model
`default_nettype wire

// ### dv/test_peak_power_limit_control.sv
// Purpose: bench
// Assumes: stage model drives the ramp
// Notes: tick is 100 cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t value mismatch", $time); end end
module test_peak_power_limit_control;
    import ppl_pkg::*;
    logic clk_sys = '0, reset_n = '0, converterEnable = '0, lightLoad = '0, vinUvloOk = '0, vbatUvloOk = '0;
    logic switchingFrequencySelect = '0, audibleNoiseAvoidEnable = '0, reverseMode = '0, batteryOnly = '0;
    logic imonGainHigh = '0, bmonGainHigh = '0, powerMonitorGainWrite = '0, powerMonitorConfigWrite = '0;
    logic reverseBatteryOnly = '0, inputSenseResSelect = '0, chargeSenseResSelect = '0, inputLimitEnable = '1;
    logic externalLimitEnable = '0, hostVinLimitWrite = '0, systemUndershootPeakEnable = '0, slow = '0;
    logic inputOvershootPeakEnable = '0, rampAboveErr, highSideSwitchOn, lowSideSwitchOn, inputMonitorValid;
    logic overloadActive, chargeSuspended, supplementEnable;
    logic [1:0] spreadSelect = '0, powerMonitorConfig = '0;
    logic [3:0] powerMonitorGain = '0;
    logic [7:0] overloadPercentage = 8'h96;
    logic signed [15:0] inputSense = 16'sh3e8, batSense = 16'sh7d0, inputCurrentMonitorOut, batteryCurrentMonitorOut;
    logic [15:0] inputVolt = 16'h4e20, sysVolt = '0, batVolt = 16'h1, busNoLoad = '0, minimumSystemVoltage = 16'h1;
    logic [15:0] inputCurrentLimit = 16'h3e8, overloadDuration = 16'h3, peakCyclePeriod = 16'h6;
    logic [15:0] hostVinLimit = 16'h4e20, chargeCurrentRequest = 16'h100, systemPowerMonitorOut, inputVoltageLimit;
    logic [15:0] activeInputLimit, chargeCurrentCmd;
    int mismatches = 0, samples_checked = 0;
    time t;
    ppl_peak_power_limit_control ppl_peak_power_limit_control_inst (.*);
    ppl_stage_model ppl_stage_model_inst (.*);
    always #5 clk_sys = ~clk_sys;
    task automatic conclude();
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog: the run needs about 9500 cycles, most of it at light load
    initial
    begin
        #200us;
        mismatches++;
        conclude();
    end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset_n <= '1;
        vinUvloOk <= '1;
        converterEnable <= '1;
        hostVinLimitWrite <= '1;
        systemUndershootPeakEnable <= '1;
        @(posedge clk_sys);
        hostVinLimitWrite <= '0;
        repeat (5) @(posedge clk_sys);
        `CHK(inputVoltageLimit, VIN_LIM_MAX_MV)
        `CHK(inputCurrentMonitorOut, 16'sh14)
        `CHK(inputMonitorValid, 1'b1)
        `CHK(supplementEnable, 1'b1)
        `CHK(systemPowerMonitorOut, 16'h0)
        powerMonitorConfig <= PMON_BUS;
        powerMonitorConfigWrite <= '1;
        @(posedge clk_sys);
        powerMonitorConfigWrite <= '0;
        repeat (2) @(posedge clk_sys);
        `CHK(systemPowerMonitorOut, 16'h2)
        reverseMode <= '1;
        repeat (2) @(posedge clk_sys);
        `CHK(inputCurrentMonitorOut, -16'sh14)
        `CHK(batteryCurrentMonitorOut, -16'sh10)
        `CHK(systemPowerMonitorOut, 16'h0)
        wait (overloadActive);
        @(negedge clk_sys);
        `CHK(activeInputLimit, 16'h5dc)
        wait (chargeSuspended);
        @(negedge clk_sys);
        `CHK(activeInputLimit, 16'h3e8)
        `CHK(chargeCurrentCmd, 16'h0)
        wait (overloadActive);
        @(negedge clk_sys);
        `CHK(chargeSuspended, 1'b0)
        repeat (101) @(posedge clk_sys);
        `CHK(chargeCurrentCmd != 16'h0, 1'b1)
        @(posedge highSideSwitchOn);
        t = $time;
        @(posedge highSideSwitchOn);
        `CHK(10'(($time - t) / 10), PERIOD_LO)
        switchingFrequencySelect <= '1;
        slow <= '1;
        repeat (2) @(posedge highSideSwitchOn);
        t = $time;
        @(posedge highSideSwitchOn);
        `CHK(10'(($time - t) / 10), PERIOD_HI)
        lightLoad <= '1;
        audibleNoiseAvoidEnable <= '1;
        @(posedge highSideSwitchOn);
        t = $time;
        @(posedge highSideSwitchOn);
        `CHK(12'(($time - t) / 10), SKIP_MAX_CYC)
        conclude();
    end
endmodule // test_peak_power_limit_control
`default_nettype wire
